// ==== hw/ana_pkg.sv ====
// package with register map, field positions and timing constants for link negotiation
//
// Function
// - start negotiation on resets, link down, restart
// - burst holds 17 clock and 16 data positions
// - data pulse present is one, absent zero
// - selector field declares standard ethernet protocol
// - sent abilities come from advertisement register
// - priority 100 full, 100 half, 10 full, 10 half
// - repeat word with ack, restart on change
// - restart when a received burst misses a clock pulse
// - advertisement write alone does not restart
// - base word only, no next page
// - no pulses: detect speed, assume half duplex
// - parallel detect link clears expansion bit 0
// - parallel detect fault sets expansion bit 4
// - partner register holds decoded or detected abilities
// - restart negotiation when receive signal lost
// - software restart stops link, waits break timer
// - negotiation off forces speed and duplex bits
// - manual bits ignored while negotiation enabled
// - half duplex carrier on tx or rx, collision
// - full duplex carrier follows rx only, no collision
// - active carrier sense follows detected carrier
// - resolved speed and duplex in speed register 1F
package ana_pkg;
  localparam logic [4:0]  REG_CTRL     = 5'h00;
  localparam logic [4:0]  REG_STAT     = 5'h01;
  localparam logic [4:0]  REG_ADV      = 5'h04;
  localparam logic [4:0]  REG_LPA      = 5'h05;
  localparam logic [4:0]  REG_EXP      = 5'h06;
  localparam logic [4:0]  REG_SPD      = 5'h1F;
  localparam int          CTRL_RESET   = 15;
  localparam int          CTRL_SPEED   = 13;
  localparam int          CTRL_ANEN    = 12;
  localparam int          CTRL_PDOWN   = 11;
  localparam int          CTRL_RESTART = 9;
  localparam int          CTRL_DUPLEX  = 8;
  localparam int          ADV_10H      = 5;
  localparam int          ADV_10F      = 6;
  localparam int          ADV_100H     = 7;
  localparam int          ADV_100F     = 8;
  localparam int          WORD_ACK     = 14;
  localparam int          EXP_LPAN     = 0;
  localparam int          EXP_PDF      = 4;
  localparam int          STAT_LINK    = 2;
  localparam int          STAT_ANDONE  = 5;
  localparam int          SPD_FIRST    = 2;
  localparam logic [4:0]  SELECTOR_STD = 5'h01;
  localparam logic [15:0] CTRL_RST_VAL = 16'h3100;
  localparam logic [15:0] ADV_RST_VAL  = 16'h01E1;
  localparam logic [15:0] ADV_WMASK    = 16'h01E0;
  localparam int          BURST_POS    = 33;
  localparam int          DATA_BITS    = 16;
  localparam int          CLK_KHZ      = 20000;
  localparam int          BREAK_MS     = 1200;
  localparam int          BREAK_CYC    = BREAK_MS * CLK_KHZ;
  localparam int          SLOT_US      = 62;
  localparam int          SLOT_CYC     = SLOT_US * CLK_KHZ / 1000;
  localparam int          MATCH_WORDS  = 3;
  localparam int          ACK_WORDS    = 6;
  localparam logic [1:0]  RES_10H      = 2'h0;
  localparam logic [1:0]  RES_10F      = 2'h1;
  localparam logic [1:0]  RES_100H     = 2'h2;
  localparam logic [1:0]  RES_100F     = 2'h3;
endpackage : ana_pkg

// ==== hw/ana_burst_if.sv ====
// interface carrying link code words between the controller and the burst coder
`timescale 1ns/1ns
`default_nettype none
interface ana_burst_if;
  logic        tx_go;
  logic [15:0] tx_word;
  logic        tx_busy;
  logic        rx_valid;
  logic [15:0] rx_word;
  logic        rx_err;
  modport ctrl (output tx_go, output tx_word, input tx_busy, input rx_valid,
                input rx_word, input rx_err);
  modport coder (input tx_go, input tx_word, output tx_busy, output rx_valid,
                 output rx_word, output rx_err);
endinterface : ana_burst_if
`default_nettype wire

// ==== hw/ana_burst_coder.sv ====
// fast link pulse burst transmitter and receiver
`timescale 1ns/1ns
`default_nettype none
module ana_burst_coder
  import ana_pkg::*;
#(
  parameter int SLOT = SLOT_CYC
) (
  input  wire logic clk,       // system clock
  input  wire logic rstn,      // sync reset, active low
  input  wire logic slot_tick, // one pulse position elapsed
  ana_burst_if.coder bus,      // word side
  output logic      tx_pulse,  // pulse request to line driver
  input  wire logic rx_pulse   // synchronised received pulse
);
  logic [5:0]  tx_pos, next_tx_pos;
  logic [15:0] tx_sh, next_tx_sh;
  logic        tx_act, next_tx_act;
  logic        next_tx_pulse;
  logic [5:0]  rx_pos, next_rx_pos;
  logic [15:0] rx_sh, next_rx_sh;
  logic        rx_seen, next_rx_seen;
  logic        next_rx_valid, next_rx_err;
  logic [15:0] next_rx_word;
  logic        rx_valid_q, rx_err_q;
  logic [15:0] rx_word_q;

  assign bus.tx_busy  = tx_act;
  assign bus.rx_valid = rx_valid_q;
  assign bus.rx_word  = rx_word_q;
  assign bus.rx_err   = rx_err_q;

  always_comb begin
    next_tx_pos   = tx_pos;
    next_tx_sh    = tx_sh;
    next_tx_act   = tx_act;
    next_tx_pulse = 1'b0;
    if (!tx_act && bus.tx_go) begin
      next_tx_act = 1'b1;
      next_tx_pos = '0;
      next_tx_sh  = bus.tx_word;
    end else if (tx_act && slot_tick) begin
      // clock framing: even index is a clock pulse, odd a data slot
      if (!tx_pos[0]) begin
        next_tx_pulse = 1'b1;
      end else begin
        next_tx_pulse = tx_sh[0];
        next_tx_sh    = {1'b0, tx_sh[15:1]};
      end
      next_tx_pos = tx_pos + 6'h01;
      if (tx_pos == 6'(BURST_POS - 1)) begin
        next_tx_act = 1'b0;
      end
    end
  end

  // receive samples each data slot; a missing clock pulse marks the burst bad
  always_comb begin
    next_rx_pos   = rx_pos;
    next_rx_sh    = rx_sh;
    next_rx_seen  = rx_seen | rx_pulse;
    next_rx_valid = 1'b0;
    next_rx_err   = 1'b0;
    next_rx_word  = rx_word_q;
    if (slot_tick) begin
      next_rx_seen = rx_pulse;
      if (rx_pos == 6'h00) begin
        if (rx_seen) begin
          next_rx_pos = 6'h01;
        end
      end else begin
        if (!rx_pos[0] && !rx_seen) begin
          next_rx_err = 1'b1;
          next_rx_pos = '0;
        end else if (rx_pos[0]) begin
          next_rx_sh = {rx_seen, rx_sh[15:1]};
        end
        if (!rx_pos[0] || rx_seen || rx_pos[0]) begin
          next_rx_pos = (!rx_pos[0] && !rx_seen) ? 6'h00 : rx_pos + 6'h01;
        end
        if (rx_pos == 6'(BURST_POS - 1) && rx_seen) begin
          next_rx_valid = 1'b1;
          next_rx_word  = rx_sh;
          next_rx_pos   = '0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_pos     <= '0;
      tx_sh      <= '0;
      tx_act     <= 1'b0;
      tx_pulse   <= 1'b0;
      rx_pos     <= '0;
      rx_sh      <= '0;
      rx_seen    <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_err_q   <= 1'b0;
      rx_word_q  <= '0;
    end else begin
      tx_pos     <= next_tx_pos;
      tx_sh      <= next_tx_sh;
      tx_act     <= next_tx_act;
      tx_pulse   <= next_tx_pulse;
      rx_pos     <= next_rx_pos;
      rx_sh      <= next_rx_sh;
      rx_seen    <= next_rx_seen;
      rx_valid_q <= next_rx_valid;
      rx_err_q   <= next_rx_err;
      rx_word_q  <= next_rx_word;
    end
  end

  burst_len_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(tx_act) |-> tx_act [*2]) else $error("burst ended too early");
  clk_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    (tx_act && slot_tick && !tx_pos[0]) |=> tx_pulse) else $error("clock pulse missing");
  data_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    (tx_act && slot_tick && tx_pos[0]) |=> tx_pulse == $past(tx_sh[0]))
    else $error("data pulse wrong");
endmodule : ana_burst_coder
`default_nettype wire

// ==== hw/ana_link_ctrl.sv ====
// auto-negotiation, parallel detection, forced mode and carrier sense control
`timescale 1ns/1ns
`default_nettype none
module ana_link_ctrl
  import ana_pkg::*;
#(
  parameter int BREAK_CYCLES = BREAK_CYC, // break link wait
  parameter int SLOT_CYCLES  = SLOT_CYC   // pulse position spacing
) (
  input  wire logic        clk,        // 20 MHz clock
  input  wire logic        rstn,       // sync reset, active low
  input  wire logic [4:0]  reg_addr,   // management register address
  input  wire logic [15:0] reg_wdata,  // write data
  input  wire logic        reg_wr,     // write strobe
  input  wire logic        reg_rd,     // read strobe
  output logic      [15:0] reg_rdata,  // read data, cycle after strobe
  input  wire logic        rx_flp,     // pin: received link pulse
  input  wire logic        rx_nlp,     // pin: normal link pulse seen
  input  wire logic        rx_mlt3,    // pin: 100M idle symbols seen
  input  wire logic        rx_signal,  // pin: receive signal present
  input  wire logic        rx_carrier, // pin: carrier on the line
  input  wire logic        tx_active,  // mac transmit activity
  output logic             tx_pulse,   // link pulse to driver
  output logic             link_up,    // link established
  output logic             link_100,   // speed 100M
  output logic             link_full,  // full duplex
  output logic             link_quiet, // transmit and receive stopped
  output logic             crs,        // carrier sense
  output logic             col         // collision
);
  typedef enum logic [5:0] {
    ANA_IDLE  = 6'b000001,
    ANA_BREAK = 6'b000010,
    ANA_ABIL  = 6'b000100,
    ANA_ACK   = 6'b001000,
    ANA_LINK  = 6'b010000,
    ANA_FORCE = 6'b100000
  } ana_state_e;

  ana_state_e  st, next_st;
  logic [15:0] ctrl, next_ctrl, adv, next_adv, lpa, next_lpa;
  logic        exp_lpan, next_exp_lpan, exp_pdf, next_exp_pdf;
  logic        done, next_done, rdy;
  logic [1:0]  res, next_res;
  logic [31:0] tmr, next_tmr;
  logic [15:0] last_rx, next_last_rx;
  logic [2:0]  cnt, next_cnt;
  logic [15:0] slot_cnt;
  logic        slot_tick;
  logic [4:0]  s1, s2;
  logic        flp_s, nlp_s, mlt_s, sig_s, car_s;
  logic        sig_d;
  logic        pdown_d;
  logic [15:0] next_rdata;
  logic [3:0]  common;
  ana_burst_if bif ();

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and slot divider
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1       <= '0;
      s2       <= '0;
      sig_d    <= 1'b0;
      slot_cnt <= '0;
      pdown_d  <= 1'b0;
    end else begin
      s1       <= {rx_flp, rx_nlp, rx_mlt3, rx_signal, rx_carrier};
      s2       <= s1;
      sig_d    <= sig_s;
      slot_cnt <= slot_tick ? '0 : slot_cnt + 16'h0001;
      pdown_d  <= ctrl[CTRL_PDOWN];
    end
  end
  assign {flp_s, nlp_s, mlt_s, sig_s, car_s} = s2;
  assign slot_tick = (slot_cnt == 16'(SLOT_CYCLES - 1));

  ana_burst_coder #(.SLOT(SLOT_CYCLES)) u_coder (
    .clk       (clk),
    .rstn      (rstn),
    .slot_tick (slot_tick),
    .bus       (bif.coder),
    .tx_pulse  (tx_pulse),
    .rx_pulse  (flp_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // negotiation state machine and registers
  // priority resolution
  assign common = adv[ADV_100F:ADV_10H] & lpa[ADV_100F:ADV_10H];

  always_comb begin
    next_st       = st;
    next_ctrl     = ctrl;
    next_adv      = adv;
    next_lpa      = lpa;
    next_exp_lpan = exp_lpan;
    next_exp_pdf  = exp_pdf;
    next_done     = done;
    next_res      = res;
    next_tmr      = tmr;
    next_last_rx  = last_rx;
    next_cnt      = cnt;
    bif.tx_go     = 1'b0;
    // selector and abilities; base word only
    bif.tx_word   = {1'b0, (st == ANA_ACK), 5'h00, adv[ADV_100F:ADV_10H], SELECTOR_STD};
    bif.tx_word[ADV_10H-1:0] = SELECTOR_STD;
    bif.tx_word[WORD_ACK+1]  = 1'b0;
    if (reg_wr && reg_addr == REG_CTRL) begin
      next_ctrl = reg_wdata;
    end
    if (reg_wr && reg_addr == REG_ADV) begin
      next_adv = (adv & ~ADV_WMASK) | (reg_wdata & ADV_WMASK);
    end
    if (!bif.tx_busy && (st == ANA_ABIL || st == ANA_ACK)) begin
      bif.tx_go = 1'b1;
    end
    case (st)
      ANA_IDLE: begin
        next_done = 1'b0;
        next_cnt  = '0;
        next_st   = ctrl[CTRL_ANEN] ? ANA_ABIL : ANA_FORCE;
      end
      ANA_BREAK: begin
        next_tmr = tmr + 32'h1;
        if (tmr == 32'(BREAK_CYCLES - 1)) begin
          next_tmr = '0;
          next_st  = ANA_IDLE;
        end
      end
      ANA_ABIL: begin
        if (bif.rx_valid) begin
          next_cnt     = (bif.rx_word == last_rx) ? cnt + 3'h1 : 3'h0;
          next_last_rx = bif.rx_word;
          next_lpa     = bif.rx_word;
          if (cnt == 3'(MATCH_WORDS - 1) && common != 4'h0) begin
            next_st  = ANA_ACK;
            next_cnt = '0;
          end
        end else if (!flp_s && (nlp_s || mlt_s)) begin
          next_lpa = 16'h0000;
          next_lpa[ADV_10H-1:0] = SELECTOR_STD;
          next_lpa[mlt_s ? ADV_100H : ADV_10H] = 1'b1;
          next_res = mlt_s ? RES_100H : RES_10H;
          if (nlp_s && mlt_s) begin
            next_exp_pdf = 1'b1;
            next_st      = ANA_IDLE;
          end else begin
            next_exp_lpan = 1'b0;
            next_done     = 1'b1;
            next_st       = ANA_LINK;
          end
        end
      end
      ANA_ACK: begin
        if (bif.rx_valid) begin
          if (bif.rx_word[WORD_ACK-1:0] != last_rx[WORD_ACK-1:0]) begin
            next_st = ANA_IDLE;
          end else if (bif.rx_word[WORD_ACK] && cnt == 3'(ACK_WORDS - 1)) begin
            next_exp_lpan = 1'b1;
            next_done     = 1'b1;
            next_res      = common[3] ? RES_100F : common[2] ? RES_100H :
                            common[1] ? RES_10F : RES_10H;
            next_st       = ANA_LINK;
          end else begin
            next_cnt = cnt + 3'h1;
          end
        end
      end
      ANA_LINK, ANA_FORCE: begin
        if (st == ANA_FORCE) begin
          next_res = {ctrl[CTRL_SPEED], ctrl[CTRL_DUPLEX]};
          if (ctrl[CTRL_ANEN]) begin
            next_st = ANA_IDLE;
          end
        end
      end
      default: next_st = ANA_IDLE;
    endcase
    if (bif.rx_err && (st == ANA_ABIL || st == ANA_ACK)) begin
      next_st = ANA_IDLE;
    end
    if (sig_d && !sig_s && st == ANA_LINK) begin
      next_st = ANA_IDLE;
    end
    // leaving power-down and software reset start a session
    if ((pdown_d && !ctrl[CTRL_PDOWN]) || ctrl[CTRL_RESET]) begin
      next_st = ANA_IDLE;
      next_ctrl[CTRL_RESET] = 1'b0;
    end
    // restart waits break timer; restart bit self-clears
    if (ctrl[CTRL_RESTART] && ctrl[CTRL_ANEN]) begin
      next_ctrl[CTRL_RESTART] = 1'b0;
      next_st  = ANA_BREAK;
      next_tmr = '0;
    end
  end

  // read data one cycle after the strobe; unmapped addresses read zero
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: next_rdata = ctrl;
        REG_STAT: begin
          next_rdata[STAT_LINK]   = link_up;
          next_rdata[STAT_ANDONE] = done;
        end
        REG_ADV:  next_rdata = adv;
        REG_LPA:  next_rdata = lpa;
        REG_EXP:  begin
          next_rdata[EXP_LPAN] = exp_lpan;
          next_rdata[EXP_PDF]  = exp_pdf;
        end
        REG_SPD:  begin
          next_rdata[SPD_FIRST+1:SPD_FIRST] = res;
          next_rdata[SPD_FIRST+2]           = rdy;
        end
        default:  next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st        <= ANA_IDLE;
      ctrl      <= CTRL_RST_VAL;
      adv       <= ADV_RST_VAL;
      lpa       <= '0;
      exp_lpan  <= 1'b0;
      exp_pdf   <= 1'b0;
      done      <= 1'b0;
      res       <= RES_10H;
      tmr       <= '0;
      last_rx   <= '0;
      cnt       <= '0;
      reg_rdata <= '0;
    end else begin
      st        <= next_st;
      ctrl      <= next_ctrl;
      adv       <= next_adv;
      lpa       <= next_lpa;
      exp_lpan  <= next_exp_lpan;
      exp_pdf   <= next_exp_pdf;
      done      <= next_done;
      res       <= next_res;
      tmr       <= next_tmr;
      last_rx   <= next_last_rx;
      cnt       <= next_cnt;
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link mode and carrier sense
  assign rdy        = (st == ANA_LINK) || (st == ANA_FORCE);
  assign link_up    = rdy & sig_s;
  assign link_100   = res[1];
  assign link_full  = res[0];
  assign link_quiet = (st == ANA_BREAK);
  // half duplex carrier; full duplex; follows carrier
  assign crs = link_full ? car_s : (car_s | tx_active);
  assign col = ~link_full & car_s & tx_active;

  ////////////////////////////////////////////////////////////////////////
  // checks on the controller
  sequence abil_to_link_s;
    st == ANA_ABIL ##1 st == ANA_LINK;
  endsequence
  sequence ack_to_link_s;
    st == ANA_ACK ##1 st == ANA_LINK;
  endsequence

  restart_clr_a: assert property (@(posedge clk) disable iff (!rstn)
    (ctrl[CTRL_RESTART] && ctrl[CTRL_ANEN]) |=> !ctrl[CTRL_RESTART] && st == ANA_BREAK)
    else $error("restart not taken");
  break_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(link_quiet) |-> link_quiet [*4]) else $error("break ended early");
  adv_norestart_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == REG_ADV && st == ANA_LINK && sig_s && sig_d && !ctrl[CTRL_RESTART]
     && !ctrl[CTRL_RESET] && !(reg_wr && reg_addr == REG_CTRL)) |=> st == ANA_LINK)
    else $error("advert write restarted");
  force_mode_a: assert property (@(posedge clk) disable iff (!rstn)
    (st == ANA_FORCE && $past(st) == ANA_FORCE) |->
    res == {$past(ctrl[CTRL_SPEED]), $past(ctrl[CTRL_DUPLEX])})
    else $error("forced mode wrong");
  force_entry_a: assert property (@(posedge clk) disable iff (!rstn)
    (st == ANA_IDLE && !ctrl[CTRL_ANEN] && !ctrl[CTRL_RESET] && !pdown_d) |=> st == ANA_FORCE)
    else $error("forced mode not entered");
  full_crs_a: assert property (@(posedge clk) disable iff (!rstn)
    link_full |-> (crs == car_s) && !col) else $error("full duplex crs wrong");
  half_crs_a: assert property (@(posedge clk) disable iff (!rstn)
    (!link_full && tx_active) |-> crs && (col == car_s)) else $error("half duplex crs wrong");
  sig_loss_a: assert property (@(posedge clk) disable iff (!rstn)
    (st == ANA_LINK && sig_d && !sig_s && !ctrl[CTRL_RESTART]) |=> st == ANA_IDLE)
    else $error("no restart on loss");
  pd_half_a: assert property (@(posedge clk) disable iff (!rstn)
    abil_to_link_s |-> !link_full) else $error("parallel detect full");
  pd_lpan_a: assert property (@(posedge clk) disable iff (!rstn)
    abil_to_link_s |-> !exp_lpan && done) else $error("partner flag not cleared");
  pd_fault_a: assert property (@(posedge clk) disable iff (!rstn)
    (st == ANA_ABIL && !bif.rx_valid && !flp_s && nlp_s && mlt_s) |=> exp_pdf)
    else $error("parallel fault not flagged");
  prio_full_a: assert property (@(posedge clk) disable iff (!rstn)
    ack_to_link_s |-> !$past(common[3]) || (link_100 && link_full))
    else $error("priority resolution wrong");
  an_done_a: assert property (@(posedge clk) disable iff (!rstn)
    ack_to_link_s |-> done && exp_lpan && rdy) else $error("negotiation done not shown");
  ack_change_a: assert property (@(posedge clk) disable iff (!rstn)
    (st == ANA_ACK && bif.rx_valid && bif.rx_word[WORD_ACK-1:0] != last_rx[WORD_ACK-1:0]
     && !ctrl[CTRL_RESTART]) |=> st == ANA_IDLE) else $error("ack change not restarted");
  bad_burst_a: assert property (@(posedge clk) disable iff (!rstn)
    (bif.rx_err && (st == ANA_ABIL || st == ANA_ACK) && !ctrl[CTRL_RESTART])
    |=> st == ANA_IDLE) else $error("no restart on bad burst");
  lpa_capture_a: assert property (@(posedge clk) disable iff (!rstn)
    (st == ANA_ABIL && bif.rx_valid) |=> lpa == $past(bif.rx_word))
    else $error("partner word not captured");
  soft_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    (ctrl[CTRL_RESET] && !ctrl[CTRL_RESTART]) |=> st == ANA_IDLE && !ctrl[CTRL_RESET])
    else $error("soft reset not taken");
endmodule : ana_link_ctrl
`default_nettype wire

// ==== dv/ana_partner_model.sv ====
// behavioural far-end link partner: sends code word bursts, decodes the device's bursts
`timescale 1ns/1ns
`default_nettype none
module ana_link_partner
  import ana_pkg::*;
#(
  parameter int SLOT = 4
) (
  input  wire logic        clk,      // system clock
  input  wire logic        rstn,     // sync reset, active low
  input  wire logic        en,       // send bursts
  input  wire logic [15:0] word,     // own code word
  input  wire logic        quiet,    // device broke the link
  input  wire logic        tx_pulse, // pulses from device
  output logic             flp,      // pulses toward device
  output logic      [15:0] seen,     // last decoded word
  output logic      [5:0]  seen_clk, // clock pulses seen
  output int               seen_n    // bursts decoded
);
  int          tc, rc, nack, nrx, pos, rpos;
  logic [15:0] w, racc;
  logic [5:0]  rclk;
  //////////////////////////////////////////////////////////////////////
  // clock positions always, data pulse is a one
  always @(posedge clk) begin
    flp <= 1'b0;
    // partner also drops the link while the device is quiet
    if (!rstn || quiet || !en) begin
      tc   <= 0;
      nack <= 0;
    end else if (nack < 12) begin
      tc <= (tc == 41 * SLOT - 1) ? 0 : tc + 1;
      if (tc == 0)
        w <= word | (16'(nrx >= 3) << WORD_ACK);
      if (tc % SLOT == 0 && tc < 33 * SLOT) begin
        pos = tc / SLOT;
        flp <= (pos % 2 == 0) || (tc != 0 && w[pos / 2]);
      end
      if (tc == 41 * SLOT - 1 && nrx >= 3)
        nack <= nack + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // decode device burst by pulse position
  always @(posedge clk) begin
    if (!rstn) begin
      rc     <= 0;
      nrx    <= 0;
      seen_n <= 0;
    end else begin
      if (quiet)
        nrx <= 0;
      if (rc > 0)
        rc <= rc + 1;
      if (tx_pulse && rc == 0) begin
        rc   <= 1;
        racc <= 16'h0000;
        rclk <= 6'h01;
      end else if (tx_pulse) begin
        rpos = (rc + SLOT / 2) / SLOT;
        if (rpos % 2 == 1)
          racc[rpos / 2] <= 1'b1;
        else
          rclk <= rclk + 6'h01;
      end
      // device bursts come back to back: close before its next first pulse
      if (rc == 33 * SLOT - 1) begin
        rc       <= 0;
        seen     <= racc;
        seen_clk <= rclk;
        nrx      <= nrx + 1;
        seen_n   <= seen_n + 1;
      end
    end
  end
endmodule : ana_link_partner
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the link negotiation controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ana_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, en = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, pword = 16'h0000, reg_rdata, seen;
  logic        rx_nlp = 1'b0, rx_mlt3 = 1'b0, rx_signal = 1'b0, rx_carrier = 1'b0;
  logic        tx_active = 1'b0, rx_flp, tx_pulse, link_up, link_100, link_full;
  logic        link_quiet, crs, col;
  logic [5:0]  seen_clk;
  int          seen_n, fail_count = 0, checked = 0;
  always #25 clk = ~clk;
  ana_link_ctrl #(.BREAK_CYCLES(20), .SLOT_CYCLES(4)) uut (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_flp(rx_flp), .rx_nlp(rx_nlp), .rx_mlt3(rx_mlt3),
    .rx_signal(rx_signal), .rx_carrier(rx_carrier), .tx_active(tx_active),
    .tx_pulse(tx_pulse), .link_up(link_up), .link_100(link_100), .link_full(link_full),
    .link_quiet(link_quiet), .crs(crs), .col(col));
  ana_link_partner #(.SLOT(4)) peer (.clk(clk), .rstn(rstn), .en(en), .word(pword),
    .quiet(link_quiet), .tx_pulse(tx_pulse), .flp(rx_flp), .seen(seen),
    .seen_clk(seen_clk), .seen_n(seen_n));
  //////////////////////////////////////////////////////////////////////
  task automatic results();
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk_reg
  task automatic chk_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      $display("Error %s expected %b seen %b", n, e, g);
      fail_count++;
    end
  endtask : chk_bit
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk_reg("rdata", e, reg_rdata & m);
  endtask : rd
  function automatic logic hit(input int s, input int v);
    if (s == 0)
      return link_up === v[0];
    return seen_n >= v;
  endfunction : hit
  task automatic wait_for(input int s, input int v);
    for (int i = 0; i < 40000 && !hit(s, v); i++)
      @(posedge clk);
    #1;
    if (!hit(s, v)) begin
      $display("Error wait %0d expected %0d seen timeout", s, v);
      fail_count++;
      results();
    end
  endtask : wait_for
  task automatic mode(input logic e100, input logic efull);
    repeat (8) @(posedge clk);
    #1 chk_bit("link_100", e100, link_100);
    chk_bit("link_full", efull, link_full);
  endtask : mode
  // the carrier line passes a two-flop synchroniser, so allow four cycles
  task automatic act(input logic t, input logic r, input logic ecrs, input logic ecol);
    @(posedge clk);
    tx_active  <= t;
    rx_carrier <= r;
    repeat (4) @(posedge clk);
    #1 chk_bit("crs", ecrs, crs);
    chk_bit("col", ecol, col);
  endtask : act
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(REG_CTRL, 16'hFFFF, CTRL_RST_VAL);
    rd(REG_ADV, 16'hFFFF, ADV_RST_VAL);
    rd(5'h02, 16'hFFFF, 16'h0000);
    wait_for(1, 1);
    chk_reg("word", 16'h01E1, seen & 16'hC1FF);
    chk_reg("clocks", 16'd17, {10'h000, seen_clk});
    // negotiated 100 half with acknowledged words
    pword     <= 16'h00E1;
    en        <= 1'b1;
    rx_signal <= 1'b1;
    wait_for(0, 1);
    mode(1'b1, 1'b0);
    chk_bit("ack", 1'b1, seen[WORD_ACK]);
    rd(REG_LPA, 16'h01FF, 16'h00E1);
    rd(REG_SPD, 16'h001C, 16'h0018);
    rd(REG_STAT, 16'h0024, 16'h0024);
    rd(REG_EXP, 16'h0001, 16'h0001);
    wr(REG_ADV, 16'hFE21);
    rd(REG_ADV, 16'hFFFF, 16'h0021);
    repeat (200) @(posedge clk);
    #1 chk_bit("link_up", 1'b1, link_up);
    wr(REG_CTRL, 16'h3300);
    @(posedge clk);
    #1 chk_bit("link_quiet", 1'b1, link_quiet);
    chk_bit("link_up", 1'b0, link_up);
    rd(REG_CTRL, 16'h0200, 16'h0000);
    wait_for(0, 1);
    mode(1'b0, 1'b0);
    chk_reg("adv", 16'h0021, seen & 16'h01FF);
    en        <= 1'b0;
    rx_signal <= 1'b0;
    wait_for(0, 0);
    rx_signal <= 1'b1;
    rx_nlp    <= 1'b1;
    wait_for(0, 1);
    mode(1'b0, 1'b0);
    rd(REG_EXP, 16'h0011, 16'h0000);
    rd(REG_LPA, 16'h01E0, 16'h0020);
    rx_mlt3   <= 1'b1;
    rx_signal <= 1'b0;
    wait_for(0, 0);
    rx_signal <= 1'b1;
    repeat (100) @(posedge clk);
    rd(REG_EXP, 16'h0010, 16'h0010);
    wr(REG_CTRL, 16'h2100);
    mode(1'b1, 1'b1);
    act(1'b1, 1'b0, 1'b0, 1'b0);
    act(1'b1, 1'b1, 1'b1, 1'b0);
    wr(REG_CTRL, 16'h0000);
    mode(1'b0, 1'b0);
    act(1'b1, 1'b0, 1'b1, 1'b0);
    act(1'b1, 1'b1, 1'b1, 1'b1);
    act(1'b0, 1'b1, 1'b1, 1'b0);
    act(1'b0, 1'b0, 1'b0, 1'b0);
    results();
  end
endmodule : testbench
`default_nettype wire
